// ===== hw/exec_defs.vh
// Constants for the literal, move, indirect-store and return executor
// How it works
// [RULE1] Bank literal load copies 4-bit literal into bank select, flags untouched.
// [RULE2] Latch literal load copies 7-bit literal into upper pc latch, flags untouched.
// [RULE3] Working literal load puts 8-bit literal into working register, one cycle.
// [RULE4] Store-working writes working register to 7-bit file address in one cycle.
// [RULE5] Indirect target is pointer plus one, minus one, unchanged, or plus offset -32..31.
// [RULE6] Mode code 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec; offset form keeps pointer.
// [RULE7] Indirect port access is redirected to the address held in its pointer.
// [RULE8] Pointers are 16 bits and wrap around at both ends.
// [RULE9] Pointer updates by indirect stores change no status flag.
// [RULE10] Return from interrupt pops the stack into the pc over two cycles.
// [RULE11] Return from interrupt also sets the global interrupt enable, bit 7.
// [RULE12] No-op and option load take one cycle; option load copies working register.
// [RULE13] Software reset sets pc to reset vector and raises a one-cycle reset request; the full reset must come from outside on rst_n.
`ifndef EXEC_DEFS_VH
`define EXEC_DEFS_VH
`define OP_NOP          4'h0
`define OP_BANK_LIT     4'h1
`define OP_PCL_LIT      4'h2
`define OP_WORK_LIT     4'h3
`define OP_STORE_FILE   4'h4
`define OP_OPTION       4'h5
`define OP_STORE_IND    4'h6
`define OP_STORE_REL    4'h7
`define OP_SW_RESET     4'h8
`define OP_RET_IRQ      4'h9
`define MODE_PRE_INC    2'h0
`define MODE_PRE_DEC    2'h1
`define MODE_POST_INC   2'h2
`define MODE_POST_DEC   2'h3
`define IND_PORT0_ADDR  7'h00
`define IND_PORT1_ADDR  7'h01
`define IRQ_EN_BIT      7
`define IRQ_CTRL_RST    8'h00
`define OPTION_RST      8'hff
`define PC_RST          15'h0000
`define RESET_VECTOR    15'h0000
`define BANK_RST        5'h00
`define LATCH_RST       7'h00
`define WORK_RST        8'h00
`define STATUS_RST      8'h00
`define MEM_ADDR_RST    16'h0000
`define MEM_DATA_RST    8'h00
`define PTR_RST         16'h0000
`endif

// ===== hw/file_pointer_unit.v
// One indirect file pointer with address and update logic
`include "exec_defs.vh"
module file_pointer_unit (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire        sel,
    input  wire        rel,
    input  wire [1:0]  index_mode_code,
    input  wire [5:0]  offset,
    output wire [15:0] target_addr,
    output reg  [15:0] file_pointer_q
);
    wire [15:0] plus1  = file_pointer_q + 16'h0001; // RULE8
    wire [15:0] minus1 = file_pointer_q - 16'h0001; // RULE8
    wire [15:0] sx_off = {{10{offset[5]}}, offset};
    wire        dec    = index_mode_code[0];
    wire        pre    = ~index_mode_code[1];
    reg  [15:0] file_pointer_d;

    // RULE5
    assign target_addr = rel ? file_pointer_q + sx_off :
                         pre ? (dec ? minus1 : plus1) : file_pointer_q;

    always @* begin
        file_pointer_d = file_pointer_q;
        if (sel && !rel) // RULE6
            file_pointer_d = dec ? minus1 : plus1;
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            file_pointer_q <= `PTR_RST;
        else
            file_pointer_q <= file_pointer_d;
    end
endmodule // file_pointer_unit

// ===== hw/literal_move_indirect_return_exec.v
// Executes literal loads, working stores, indirect stores and interrupt return
`include "exec_defs.vh"
module literal_move_indirect_return_exec (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire        op_valid,
    input  wire [3:0]  op_code,
    input  wire [7:0]  literal,
    input  wire [6:0]  file_addr,
    input  wire        ptr_sel,
    input  wire [1:0]  index_mode_code,
    input  wire [5:0]  rel_offset,
    input  wire [14:0] stack_top,
    input  wire [7:0]  status_in,
    output wire        op_ready,
    output reg         stack_pop_q,
    output reg  [14:0] pc_q,
    output reg  [4:0]  bank_select_reg_q,
    output reg  [6:0]  pc_upper_latch_q,
    output reg  [7:0]  working_q,
    output reg  [7:0]  option_q,
    output reg  [7:0]  irq_control_reg_q,
    output reg  [7:0]  status_q,
    output reg         mem_we_q,
    output reg  [15:0] mem_addr_q,
    output reg  [7:0]  mem_wdata_q,
    output reg         sw_reset_req_q,
    output wire [15:0] file_pointer_0,
    output wire [15:0] file_pointer_1
);
    localparam ST_RUN = 2'b01;
    localparam ST_RET = 2'b10;

    reg  [1:0]  state_q;
    wire        go   = op_valid && op_ready;
    wire        ind  = go && (op_code == `OP_STORE_IND || op_code == `OP_STORE_REL);
    wire        rel  = op_code == `OP_STORE_REL;
    wire [15:0] tgt0;
    wire [15:0] tgt1;

    // Return takes a second cycle, so new ops wait
    assign op_ready = (state_q == ST_RUN) && !sw_reset_req_q;

    file_pointer_unit u_ptr0 (
        .clk_sys         (clk_sys),
        .rst_n           (rst_n),
        .sel             (ind && !ptr_sel),
        .rel             (rel),
        .index_mode_code (index_mode_code),
        .offset          (rel_offset),
        .target_addr     (tgt0),
        .file_pointer_q  (file_pointer_0)
    );

    file_pointer_unit u_ptr1 (
        .clk_sys         (clk_sys),
        .rst_n           (rst_n),
        .sel             (ind && ptr_sel),
        .rel             (rel),
        .index_mode_code (index_mode_code),
        .offset          (rel_offset),
        .target_addr     (tgt1),
        .file_pointer_q  (file_pointer_1)
    );

    // One strobe per op, each already gated by acceptance
    wire        do_bank  = go && (op_code == `OP_BANK_LIT);
    wire        do_latch = go && (op_code == `OP_PCL_LIT);
    wire        do_wlit  = go && (op_code == `OP_WORK_LIT);
    wire        do_opt   = go && (op_code == `OP_OPTION);
    wire        do_file  = go && (op_code == `OP_STORE_FILE);
    wire        do_reset = go && (op_code == `OP_SW_RESET);
    wire        do_ret   = go && (op_code == `OP_RET_IRQ);
    // Direct and indirect stores share one write port
    wire        do_store = do_file || ind;

    reg  [1:0]  state_d;
    reg  [14:0] pc_d;
    reg  [15:0] mem_addr_d;
    reg  [7:0]  working_d;
    reg  [7:0]  option_d;

    always @* begin
        state_d = state_q;
        case (state_q)
        ST_RUN: begin
            if (do_ret)
                state_d = ST_RET; // RULE10
        end
        // Second return cycle refuses new ops
        ST_RET: state_d = ST_RUN; // RULE10
        default: state_d = ST_RUN;
        endcase
    end

    // Unknown codes fall through here as a plain advance
    always @* begin
        pc_d = pc_q;
        if (do_reset)
            pc_d = `RESET_VECTOR; // RULE13
        else if (do_ret)
            pc_d = stack_top; // RULE10
        else if (go)
            pc_d = pc_q + 15'h0001; // RULE12
    end

    // Ports 0 and 1 are windows for direct stores; indirect targets 0 and 1 go out as is
    always @* begin
        mem_addr_d = mem_addr_q;
        if (ind)
            mem_addr_d = ptr_sel ? tgt1 : tgt0; // RULE5
        else if (do_file) begin
            if (file_addr == `IND_PORT0_ADDR) // RULE7
                mem_addr_d = file_pointer_0;
            else if (file_addr == `IND_PORT1_ADDR)
                mem_addr_d = file_pointer_1;
            else
                mem_addr_d = {9'h000, file_addr};
        end
    end

    // Option load sees working as it stood before this op
    always @* begin
        working_d = working_q;
        option_d  = option_q;
        if (do_wlit)
            working_d = literal; // RULE3
        if (do_opt)
            option_d = working_q; // RULE12
    end

    // Every register has its own reset so each rule sits by its flop
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            state_q <= ST_RUN;
        else
            state_q <= state_d;
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            pc_q <= `PC_RST;
        else
            pc_q <= pc_d;
    end

    // Pop lasts one cycle; the stack itself lives outside this block
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            stack_pop_q <= 1'b0;
        else
            stack_pop_q <= do_ret; // RULE10
    end

    // Only a request: the outside reset controller must pull rst_n
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            sw_reset_req_q <= 1'b0;
        else
            sw_reset_req_q <= do_reset; // RULE13
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            bank_select_reg_q <= `BANK_RST;
        else if (do_bank)
            bank_select_reg_q <= {1'b0, literal[3:0]}; // RULE1
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            pc_upper_latch_q <= `LATCH_RST;
        else if (do_latch)
            pc_upper_latch_q <= literal[6:0]; // RULE2
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            working_q <= `WORK_RST;
        else
            working_q <= working_d;
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            option_q <= `OPTION_RST;
        else
            option_q <= option_d;
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            irq_control_reg_q <= `IRQ_CTRL_RST;
        else if (do_ret)
            irq_control_reg_q[`IRQ_EN_BIT] <= 1'b1; // RULE11
    end

    // Status is only carried through; no op here may alter a flag
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            status_q <= `STATUS_RST;
        else
            status_q <= status_in; // RULE9
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            mem_we_q <= 1'b0;
        else
            mem_we_q <= do_store; // RULE4
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            mem_addr_q <= `MEM_ADDR_RST;
        else
            mem_addr_q <= mem_addr_d;
    end

    // Data holds after the strobe so a slow sink may still read it
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            mem_wdata_q <= `MEM_DATA_RST;
        else if (do_store)
            mem_wdata_q <= working_q;
    end
endmodule // literal_move_indirect_return_exec

// ===== sim/exec_monitor.sv
// Port checker for the executor
`include "exec_defs.vh"
module exec_monitor (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        op_valid,
    input wire logic [3:0]  op_code,
    input wire logic [7:0]  literal,
    input wire logic [14:0] stack_top,
    input wire logic [7:0]  status_in,
    input wire logic        op_ready,
    input wire logic        stack_pop_q,
    input wire logic [14:0] pc_q,
    input wire logic [4:0]  bank_select_reg_q,
    input wire logic [7:0]  working_q,
    input wire logic [7:0]  irq_control_reg_q,
    input wire logic [7:0]  status_q,
    input wire logic        mem_we_q,
    input wire logic        sw_reset_req_q
);
    timeunit 1ns;
    timeprecision 1ns;
    wire acc = op_valid && op_ready;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    chk_bank_load: assert property (acc && op_code == `OP_BANK_LIT
        |=> bank_select_reg_q == {1'b0, $past(literal[3:0])}) else $error("bank load wrong");
    chk_work_load: assert property (acc && op_code == `OP_WORK_LIT
        |=> working_q == $past(literal)) else $error("working load wrong");
    chk_ret_pop: assert property (acc && op_code == `OP_RET_IRQ
        |=> stack_pop_q && pc_q == $past(stack_top) && !op_ready ##1 !stack_pop_q)
        else $error("return pop wrong");
    chk_ret_gie: assert property (acc && op_code == `OP_RET_IRQ
        |=> irq_control_reg_q[`IRQ_EN_BIT]) else $error("enable not set");
    chk_status_kept: assert property ($past(rst_n)
        |-> status_q == $past(status_in)) else $error("status changed");
    chk_store_strobe: assert property (acc && op_code == `OP_STORE_FILE
        |=> mem_we_q) else $error("no write strobe");
    chk_nop_quiet: assert property (acc && op_code == `OP_NOP
        |=> !mem_we_q && !stack_pop_q && $stable(working_q)) else $error("nop acted");
    chk_sw_reset: assert property (acc && op_code == `OP_SW_RESET
        |=> sw_reset_req_q) else $error("no reset request");
    cover property (acc && op_code == `OP_STORE_IND);
    cover property (acc && op_code == `OP_RET_IRQ);
    cover property (acc && op_code == `OP_SW_RESET);
endmodule // exec_monitor
bind literal_move_indirect_return_exec exec_monitor mon (.*);

// ===== sim/tb.sv
// Self-checking bench for the executor
`include "exec_defs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys, rst_n, op_valid, ptr_sel, op_ready, stack_pop_q, mem_we_q;
    logic        sw_reset_req_q;
    logic [3:0]  op_code;
    logic [7:0]  literal, status_in, working_q, option_q, irq_control_reg_q, status_q;
    logic [7:0]  mem_wdata_q, w, st;
    logic [6:0]  file_addr, pc_upper_latch_q;
    logic [1:0]  index_mode_code;
    logic [5:0]  rel_offset;
    logic [14:0] stack_top, pc_q, pc;
    logic [4:0]  bank_select_reg_q;
    logic [15:0] mem_addr_q, file_pointer_0, file_pointer_1, ea;
    logic [15:0] fp [2];
    int          fails, compares, i, n;
    literal_move_indirect_return_exec uut (
        .clk_sys           (clk_sys),
        .rst_n             (rst_n),
        .op_valid          (op_valid),
        .op_code           (op_code),
        .literal           (literal),
        .file_addr         (file_addr),
        .ptr_sel           (ptr_sel),
        .index_mode_code   (index_mode_code),
        .rel_offset        (rel_offset),
        .stack_top         (stack_top),
        .status_in         (status_in),
        .op_ready          (op_ready),
        .stack_pop_q       (stack_pop_q),
        .pc_q              (pc_q),
        .bank_select_reg_q (bank_select_reg_q),
        .pc_upper_latch_q  (pc_upper_latch_q),
        .working_q         (working_q),
        .option_q          (option_q),
        .irq_control_reg_q (irq_control_reg_q),
        .status_q          (status_q),
        .mem_we_q          (mem_we_q),
        .mem_addr_q        (mem_addr_q),
        .mem_wdata_q       (mem_wdata_q),
        .sw_reset_req_q    (sw_reset_req_q),
        .file_pointer_0    (file_pointer_0),
        .file_pointer_1    (file_pointer_1)
    );
    task automatic finish_test();
        if (fails == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic store(input logic [15:0] a);
        cmp(16'(mem_we_q), 16'h0001);
        cmp(mem_addr_q, a);
        cmp(16'(mem_wdata_q), 16'(w));
    endtask
    // Waits out the refused cycle after a return
    task automatic issue(input logic [3:0] c);
        n = 0;
        while (op_ready !== 1'b1) begin
            if (++n > 4) begin fails++; finish_test(); end
            @(posedge clk_sys) #1;
        end
        @(posedge clk_sys);
        op_code <= c;
        op_valid <= 1'b1;
        status_in <= st;
        literal <= c == `OP_BANK_LIT ? 8'($urandom_range(0, 15)) : 8'($urandom);
        file_addr <= $urandom_range(0, 1) ? 7'($urandom) : 7'($urandom_range(0, 1));
        ptr_sel <= i < 2 ? i[0] : 1'($urandom);
        index_mode_code <= i < 2 ? 2'h1 : 2'($urandom);
        rel_offset <= 6'($urandom);
        stack_top <= 15'($urandom);
        @(posedge clk_sys);
        op_valid <= 1'b0;
        #1;
    endtask
    task automatic run_ops(input int cnt);
        for (i = 0; i < cnt; i++) begin
            st = 8'($urandom);
            issue(i < 2 ? `OP_STORE_IND : 4'($urandom_range(0, 7)));
            pc = pc + 15'h0001;
            case (op_code)
                `OP_BANK_LIT: cmp(16'(bank_select_reg_q), 16'(literal));
                `OP_PCL_LIT: cmp(16'(pc_upper_latch_q), 16'(literal[6:0]));
                `OP_WORK_LIT: w = literal;
                `OP_OPTION: cmp(16'(option_q), 16'(w));
                `OP_STORE_FILE: store(file_addr < 2 ? fp[file_addr[0]] : 16'(file_addr));
                `OP_STORE_REL: store(fp[ptr_sel] + {{10{rel_offset[5]}}, rel_offset});
                `OP_STORE_IND: begin
                    ea = fp[ptr_sel];
                    fp[ptr_sel] = ea + (index_mode_code[0] ? 16'hffff : 16'h0001);
                    store(index_mode_code[1] ? ea : fp[ptr_sel]);
                end
                default: ;
            endcase
            cmp(16'(working_q), 16'(w));
            cmp(16'(status_q), 16'(st));
            cmp(file_pointer_0, fp[0]);
            cmp(file_pointer_1, fp[1]);
            cmp(16'(pc_q), 16'(pc));
        end
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        {rst_n, op_valid, op_code, literal, file_addr, ptr_sel, st, w} = '0;
        {index_mode_code, rel_offset, stack_top, status_in, fp[0], fp[1], pc} = '0;
        void'($urandom(35));
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        run_ops(80);
        issue(`OP_RET_IRQ);
        cmp(16'(pc_q), 16'(stack_top));
        cmp(16'(stack_pop_q), 16'h0001);
        cmp(16'(op_ready), 16'h0000);
        cmp(16'(irq_control_reg_q[`IRQ_EN_BIT]), 16'h0001);
        issue(`OP_SW_RESET);
        cmp(16'(sw_reset_req_q), 16'h0001);
        cmp(16'(pc_q), 16'(`RESET_VECTOR));
        // Stand-in for the outside reset controller
        @(posedge clk_sys);
        rst_n <= 1'b0;
        @(posedge clk_sys) #1;
        cmp(16'(option_q), 16'h00ff);
        cmp(16'(irq_control_reg_q), 16'h0000);
        {w, pc, fp[0], fp[1]} = '0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        run_ops(10);
        finish_test();
    end
endmodule // tb
